// >>> common/scs_pkg.sv
// Constants shared by the serial converter clock sequencer.
// Assumes a 10 MHz system clock that oversamples the serial I/O clock.
package scs_pkg;
  localparam int unsigned RES_BITS   = 12;
  localparam int unsigned IN_BITS    = 8;
  localparam int unsigned ADDR_BITS  = 4;
  localparam int unsigned CNT_BITS   = 4;
  localparam int unsigned FIFO_DEPTH = 2;
  localparam int unsigned PTR_BITS   = 1;
  localparam logic [CNT_BITS-1:0] ADDR_EDGE   = 4'h4;
  localparam logic [CNT_BITS-1:0] SAMPLE_EDGE = 4'h4;
  localparam logic [CNT_BITS-1:0] IN_EDGES    = 4'h8;
  localparam logic [CNT_BITS-1:0] LAST_EDGE   = 4'hc;
  localparam logic [1:0]          CNT_ZERO2   = 2'h0;
  localparam logic [1:0]          CNT_FULL2   = 2'h2;

  typedef enum logic [1:0] {
    SCS_IDLE = 2'b00,
    SCS_XFER = 2'b01,
    SCS_CONV = 2'b10
  } scs_state_t;
endpackage

// >>> core/scs_sequencer.sv
// Serial interface sequencer for a 12-bit sampling converter.
// Assumes chip select, I/O clock and command input arrive from pins and
// an analog core takes sample/convert strobes and returns results.
// Functional notes
// - End flag falls after last falling edge
// - End flag low until result ready
// - Capture eight input bits on rising edges
// - Channel valid after fourth rising edge
// - Sample from fourth to last falling edge
// - Shift out remaining eleven previous bits
// - Result output changes on falling edges and at select
// - Last falling edge starts internal conversion
// - Chip select fall resets counters unless converting, enables pins
// - Result output driven only while selected
// - First result bit driven at select
`timescale 1ns/100ps
module scs_sequencer
  import scs_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 reset_in,
  // Serial pins
  input  wire logic                 cs_n_in,
  input  wire logic                 io_clock_in,
  input  wire logic                 cmd_data_in,
  output logic                      result_data_out,
  output logic                      result_data_oe_out,
  output logic                      eoc_out,
  // Analog core control
  output logic [ADDR_BITS-1:0]      channel_out,
  output logic                      channel_valid_out,
  output logic [IN_BITS-1:0]        cmd_word_out,
  output logic                      sample_out,
  output logic                      convert_start_out,
  // Result stream from analog core
  input  wire logic [RES_BITS-1:0]  result_in,
  input  wire logic                 result_valid_in,
  output logic                      result_ready_out
);

  // Pin synchronisers
  logic [2:0] cs_sync_q;
  logic [2:0] clk_sync_q;
  logic [1:0] din_sync_q;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cs_sync_q  <= 3'h7;
      clk_sync_q <= 3'h0;
      din_sync_q <= 2'h0;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], cs_n_in};
      clk_sync_q <= {clk_sync_q[1:0], io_clock_in};
      din_sync_q <= {din_sync_q[0], cmd_data_in};
    end
  end

  wire cs_n     = cs_sync_q[1];
  wire cs_fall  = cs_sync_q[2] & ~cs_sync_q[1];
  wire clk_rise = ~clk_sync_q[2] & clk_sync_q[1];
  wire clk_fall = clk_sync_q[2] & ~clk_sync_q[1];
  wire din      = din_sync_q[1];

  // Sequencer state, needed by the buffer pop
  scs_state_t          state_q;

  // Result buffer, two entries
  logic [RES_BITS-1:0] fifo_mem_q [FIFO_DEPTH];
  logic [PTR_BITS-1:0] wr_ptr_q;
  logic [PTR_BITS-1:0] rd_ptr_q;
  logic [1:0]          fifo_cnt_q;
  logic                not_full_q;

  wire fifo_empty = (fifo_cnt_q == CNT_ZERO2);
  wire fifo_push  = result_valid_in & not_full_q;
  wire frame_ok   = cs_fall & (state_q != SCS_CONV);
  wire fifo_pop   = frame_ok & ~fifo_empty;
  wire [1:0] fifo_cnt_d = fifo_cnt_q + {1'b0, fifo_push} - {1'b0, fifo_pop};

  always_ff @(posedge clock_in) begin
    if (fifo_push) begin
      fifo_mem_q[wr_ptr_q] <= result_in;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      fifo_cnt_q <= CNT_ZERO2;
      not_full_q <= 1'b1;
    end else begin
      wr_ptr_q   <= wr_ptr_q + PTR_BITS'(fifo_push);
      rd_ptr_q   <= rd_ptr_q + PTR_BITS'(fifo_pop);
      fifo_cnt_q <= fifo_cnt_d;
      not_full_q <= (fifo_cnt_d != CNT_FULL2);
    end
  end

  assign result_ready_out = not_full_q;

  // Sequencer registers
  logic [CNT_BITS-1:0] rise_cnt_q;
  logic [CNT_BITS-1:0] fall_cnt_q;
  logic [IN_BITS-1:0]  in_shift_q;
  logic [RES_BITS-1:0] out_shift_q;
  logic [RES_BITS-1:0] last_result_q;
  logic                dout_q;
  logic                oe_q;
  logic                eoc_q;
  logic                sample_q;
  logic                start_q;
  logic [ADDR_BITS-1:0] chan_q;
  logic                chan_valid_q;
  logic [IN_BITS-1:0]  cmd_q;

  wire in_xfer     = (state_q == SCS_XFER);
  wire take_rise   = in_xfer & clk_rise & (rise_cnt_q < IN_EDGES);
  wire take_fall   = in_xfer & clk_fall & (fall_cnt_q < LAST_EDGE);
  wire [CNT_BITS-1:0] rise_next = rise_cnt_q + 4'h1;
  wire [CNT_BITS-1:0] fall_next = fall_cnt_q + 4'h1;
  wire last_fall   = take_fall & (fall_next == LAST_EDGE);
  // Conversion handed over on last fall
  wire conv_go     = last_fall & ~frame_ok & ~(in_xfer & cs_n);
  wire conv_done   = (state_q == SCS_CONV) & fifo_push;
  wire [RES_BITS-1:0] load_word = fifo_empty ? last_result_q : fifo_mem_q[rd_ptr_q];
  wire [IN_BITS-1:0]  in_next   = {in_shift_q[IN_BITS-2:0], din};

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_q       <= SCS_IDLE;
      rise_cnt_q    <= '0;
      fall_cnt_q    <= '0;
      in_shift_q    <= '0;
      out_shift_q   <= '0;
      last_result_q <= '0;
      dout_q        <= 1'b0;
      oe_q          <= 1'b0;
      sample_q      <= 1'b0;
      start_q       <= 1'b0;
      chan_q        <= '0;
      chan_valid_q  <= 1'b0;
      cmd_q         <= '0;
    end else begin
      start_q <= 1'b0;
      oe_q    <= ~cs_n;
      if (frame_ok) begin
        state_q       <= SCS_XFER;
        rise_cnt_q    <= '0;
        fall_cnt_q    <= '0;
        chan_valid_q  <= 1'b0;
        sample_q      <= 1'b0;
        out_shift_q   <= load_word;
        last_result_q <= load_word;
        dout_q        <= load_word[RES_BITS-1];
      end else if (in_xfer && cs_n) begin
        state_q  <= SCS_IDLE;
        sample_q <= 1'b0;
      end else begin
        if (take_rise) begin
          rise_cnt_q <= rise_next;
          in_shift_q <= in_next;
          if (rise_next == ADDR_EDGE) begin
            chan_q       <= in_next[ADDR_BITS-1:0];
            chan_valid_q <= 1'b1;
          end
          if (rise_next == IN_EDGES) begin
            cmd_q <= in_next;
          end
        end
        if (take_fall) begin
          fall_cnt_q <= fall_next;
          out_shift_q <= {out_shift_q[RES_BITS-2:0], 1'b0};
          dout_q      <= out_shift_q[RES_BITS-2];
          if (fall_next == SAMPLE_EDGE) begin
            sample_q <= 1'b1;
          end
        end
        if (last_fall) begin
          state_q  <= SCS_CONV;
          sample_q <= 1'b0;
          start_q  <= 1'b1;
        end
        if (conv_done) begin
          state_q <= SCS_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      eoc_q <= 1'b1;
    end else if (conv_done) begin
      eoc_q <= 1'b1;
    end else if (conv_go) begin
      eoc_q <= 1'b0;
    end
  end

  assign result_data_out    = dout_q;
  assign result_data_oe_out = oe_q;
  assign eoc_out            = eoc_q;
  assign channel_out        = chan_q;
  assign channel_valid_out  = chan_valid_q;
  assign cmd_word_out       = cmd_q;
  assign sample_out         = sample_q;
  assign convert_start_out  = start_q;

endmodule // scs_sequencer

// >>> verif/scs_host_model.sv
// Host serial port model: frames a transfer, sends a command, reads a result.
// Runs off the bench clock; io clock idles low between frames.
`timescale 1ns/100ps
module scs_host_model (
  input  wire logic   clock_in,
  input  wire logic   result_data_in,
  output logic        cs_n_out = 1'b1,
  output logic        io_clock_out = 1'b0,
  output logic        cmd_data_out = 1'b0,
  output logic [11:0] rx_out = 12'h000
);
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic xfer(input logic [7:0] cmd);
    cs_n_out = 1'b0;
    step(16);
    for (int i = 0; i < 12; i++) begin
      cmd_data_out = (i < 8) ? cmd[7 - i] : ~cmd_data_out;
      step(4);
      io_clock_out = 1'b1;
      rx_out = {rx_out[10:0], result_data_in};
      step(4);
      io_clock_out = 1'b0;
    end
    step(4);
    cs_n_out = 1'b1;
  endtask
endmodule // scs_host_model

// >>> verif/scs_sequencer_chk.sv
// Pin and strobe assertions for the sequencer.
// Bound into each scs_sequencer by the bind below.
`timescale 1ns/100ps
module scs_sequencer_chk (
  input wire logic       clock_in, reset_in, cs_n_in, io_clock_in,
  input wire logic       eoc_out, result_data_out, result_data_oe_out,
  input wire logic [3:0] channel_out,
  input wire logic [7:0] cmd_word_out,
  input wire logic       channel_valid_out, sample_out, convert_start_out,
  input wire logic       result_valid_in, result_ready_out
);
  wire push_w = result_valid_in && result_ready_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  a_eoc_falls: assert property (convert_start_out |-> ##[0:1] !eoc_out)
    else $error("eoc high at start");
  a_eoc_holds: assert property (!eoc_out && !push_w |=> !eoc_out)
    else $error("eoc rose early");
  a_eoc_rises: assert property (!eoc_out && push_w |=> eoc_out)
    else $error("eoc stuck low");
  a_pin_free: assert property (cs_n_in [*5] |-> !result_data_oe_out)
    else $error("pin driven unselected");
  a_data_fall: assert property ($changed(result_data_out) && $past(result_data_oe_out)
    && result_data_oe_out |-> !$past(io_clock_in)) else $error("data moved off fall");
  a_sample_chan: assert property ($rose(sample_out) |-> channel_valid_out)
    else $error("sample before channel");
  a_start_pulse: assert property (convert_start_out |-> $fell(sample_out) ##1 !convert_start_out)
    else $error("bad start pulse");
  a_chan_stable: assert property (channel_valid_out && $past(channel_valid_out) |-> $stable(channel_out))
    else $error("channel moved");
  a_word_chan: assert property ($changed(cmd_word_out) && channel_valid_out |->
    cmd_word_out[7:4] == channel_out) else $error("word and channel differ");
endmodule // scs_sequencer_chk
bind scs_sequencer scs_sequencer_chk u_chk (.*);

// >>> verif/tb_scs_sequencer.sv
// Self-checking bench: host model on the pins, bench acts as analog core.
// Needs scs_pkg, scs_sequencer, the host model and the checker.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h seen %h", n, e, g); end end
module tb_scs_sequencer;
  logic        clock_in = 1'b0, reset_in = 1'b1, result_valid_in = 1'b0;
  logic [11:0] result_in = 12'h000, rx;
  logic        cs_n_in, io_clock_in, cmd_data_in, result_data_out, result_data_oe_out;
  logic        eoc_out, channel_valid_out, sample_out, convert_start_out, result_ready_out;
  logic [3:0]  channel_out;
  logic [7:0]  cmd_word_out;
  int          errors = 0, samples_checked = 0, cycles = 0, starts = 0;
  always #50 clock_in = ~clock_in;
  scs_host_model host (.clock_in(clock_in), .result_data_in(result_data_out),
    .cs_n_out(cs_n_in), .io_clock_out(io_clock_in), .cmd_data_out(cmd_data_in), .rx_out(rx));
  scs_sequencer dut (.*);
  always @(posedge clock_in) begin
    cycles++;
    if (convert_start_out === 1'b1) starts++;
    if (cycles == 3000) begin errors++; give_verdict(); end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic push(input logic [11:0] w);
    result_in = w;
    result_valid_in = 1'b1;
    while (result_ready_out !== 1'b1) tick(1);
    tick(1);
  endtask
  task automatic t_fill();
    push(12'ha5c);
    push(12'h3c1);
    result_valid_in = 1'b0;
    tick(2);
    `CHK("ready", 1'b0, result_ready_out)
    `CHK("eoc", 1'b1, eoc_out)
    $display("test fill done");
  endtask
  task automatic t_xfer(input logic [7:0] cmd, input logic [11:0] exp, nxt);
    host.xfer(cmd);
    tick(2);
    `CHK("result", exp, rx)
    `CHK("channel", cmd[7:4], channel_out)
    `CHK("word", cmd, cmd_word_out)
    `CHK("eoc low", 1'b0, eoc_out)
    `CHK("sample", 1'b0, sample_out)
    tick(10);
    `CHK("eoc held", 1'b0, eoc_out)
    push(nxt);
    result_valid_in = 1'b0;
    tick(1);
    `CHK("eoc high", 1'b1, eoc_out)
    $display("test xfer done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tick(8);
    reset_in = 1'b0;
    tick(1);
    `CHK("oe", 1'b0, result_data_oe_out)
    t_fill();
    t_xfer(8'hb6, 12'ha5c, 12'h7e3);
    t_xfer(8'h3c, 12'h3c1, 12'h0f9);
    t_xfer(8'h75, 12'h7e3, 12'h5a6);
    `CHK("starts", 3, starts)
    give_verdict();
  end
endmodule // tb_scs_sequencer
